// ---- shared/crf_pkg.sv ----
// Package with constants, types and shared helpers of the core register file.
`default_nettype none
package crf_pkg;
  localparam int CRF_NREG = 16;
  localparam int CRF_WIDE_FIRST = 12;
  localparam logic [3:0] CRF_IDX_SP = 4'hf;
  localparam logic [3:0] CRF_IDX_LAST_PAIR = 4'hb;
  localparam logic [3:0] CRF_IDX_LAST_SHORT = 4'hd;

  typedef enum logic [1:0] {
    CRF_SZ_BYTE,
    CRF_SZ_WORD,
    CRF_SZ_PAIR
  } crf_size_t;

  // Bus word offsets of the registers, decoded from address bits 4:2.
  localparam logic [2:0] CRF_OFS_PC = 3'h0;
  localparam logic [2:0] CRF_OFS_ISTK = 3'h1;
  localparam logic [2:0] CRF_OFS_USTK = 3'h2;
  localparam logic [2:0] CRF_OFS_BASE = 3'h3;
  localparam logic [2:0] CRF_OFS_PSR = 3'h4;
  localparam logic [2:0] CRF_OFS_CFG = 3'h5;
  localparam logic [2:0] CRF_OFS_STACK = 3'h6;

  // Status word fields.
  localparam int CRF_USER_MODE_FLAG = 3;
  localparam logic [15:0] CRF_PSR_RESET = 16'h0200;
  localparam logic [15:0] CRF_PSR_WMASK = 16'h0eef;
  // Configuration word fields.
  localparam int CRF_SHORT_REGISTER_SELECT = 9;
  localparam logic [15:0] CRF_CFG_RESET = 16'h0000;
  localparam logic [15:0] CRF_CFG_WMASK = 16'h0300;

  localparam logic [23:0] CRF_PC_START = 24'h000000;
  localparam logic [31:0] CRF_ISTK_MASK = 32'h00fffffe;
  localparam logic [31:0] CRF_USTK_LIMIT = 32'h00ffffff;

  // True when the index names a pair built from two 16-bit halves.
  function automatic logic crf_is_pair(input logic [3:0] idx,
                                       input logic short_reg);
    crf_is_pair = (idx <= CRF_IDX_LAST_PAIR) ||
                  (short_reg && idx <= CRF_IDX_LAST_SHORT);
  endfunction
endpackage
`default_nettype wire

// ---- hdl/crf_read_port.sv ----
// One registered operand read port with pair forming and sizing.
`default_nettype none
module crf_read_port
  import crf_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [511:0] regs_flat,
  input wire logic short_reg,
  input wire logic [3:0] rd_idx,
  input wire crf_size_t rd_size,
  output logic [31:0] rd_data_r
);
  logic [31:0] full;
  logic [15:0] upper_half;
  logic [3:0] up_idx;
  logic [31:0] rd_nxt;

  always_comb begin
    up_idx = 4'(rd_idx + 4'h1);
    full = regs_flat[{rd_idx, 5'h00} +: 32];
    upper_half = regs_flat[{up_idx, 5'h00} +: 16];
    unique case (rd_size)
      CRF_SZ_BYTE: rd_nxt = {24'h000000, full[7:0]};
      CRF_SZ_WORD: rd_nxt = {16'h0000, full[15:0]};
      CRF_SZ_PAIR: begin
        if (crf_is_pair(rd_idx, short_reg)) begin
          rd_nxt = {upper_half, full[15:0]};
        end else begin
          rd_nxt = full;
        end
      end
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // Read data settle one edge after the request, already holding a write
  // made in the request cycle.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_r <= 32'h00000000;
    end else begin
      rd_data_r <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/crf_regfile.sv ----
// Core register file with dedicated address registers and bus access.
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`default_nettype none
module crf_regfile
  import crf_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic warm_reset,
  input wire logic [3:0] rd_a_idx,
  input wire crf_size_t rd_a_size,
  output logic [31:0] rd_a_data,
  input wire logic [3:0] rd_b_idx,
  input wire crf_size_t rd_b_size,
  output logic [31:0] rd_b_data,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire crf_size_t wr_size,
  input wire logic [31:0] wr_data,
  input wire logic pc_load,
  input wire logic [23:0] pc_value,
  output logic [23:0] instruction_address_counter,
  input wire logic psr_load,
  input wire logic [15:0] psr_value,
  output logic [15:0] processor_status_word,
  output logic short_register_select,
  input wire logic stk_access,
  input wire logic stk_load,
  input wire logic [31:0] stk_value,
  output logic [31:0] stack_pointer,
  input wire logic exc_push,
  input wire logic exc_pop,
  input wire logic [15:0] exc_bytes,
  output logic [31:0] interrupt_stack_pointer,
  output logic [31:0] dispatch_table_base,
  output logic illegal_address_trap,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  logic [31:0] regs_r [CRF_NREG];
  logic [31:0] regs_nxt [CRF_NREG];
  logic [511:0] regs_flat;
  logic [23:0] pc_r;
  logic [31:0] istk_r;
  logic [31:0] ustk_r;
  logic [31:0] base_r;
  logic [15:0] psr_r;
  logic [15:0] cfg_r;
  logic [31:0] stack_ptr_r;
  logic trap_r;
  logic waitreq_r;
  logic [31:0] readdata_r;
  logic [31:0] readdata_nxt;
  logic [31:0] ustk_nxt;
  logic bus_wr;
  logic bus_req;
  logic [2:0] bus_ofs;
  logic user_mode_flag;
  logic wr_paired;
  logic [3:0] wr_up_idx;

  // Merge write data into an old value under the bus byte enables.
  function automatic logic [31:0] crf_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    crf_merge = res;
  endfunction

  assign user_mode_flag = psr_r[CRF_USER_MODE_FLAG];
  assign bus_req = avs_read || avs_write;
  assign bus_ofs = avs_address[4:2];
  // A write lands only on the edge where the master sees waitrequest low.
  assign bus_wr = avs_write && !waitreq_r;
  assign wr_paired = crf_is_pair(wr_idx, cfg_r[CRF_SHORT_REGISTER_SELECT]);
  assign wr_up_idx = 4'(wr_idx + 4'h1);

  // Next value of each general register. Readers sample these next
  // values, so a write is seen by a read issued in the same cycle.
  genvar g;
  generate
    for (g = 0; g < CRF_NREG; g++) begin : gen_reg
      always_comb begin
        regs_nxt[g] = regs_r[g];
        if (warm_reset) begin
          if (g == 0) begin
            regs_nxt[g][15:0] = pc_r[15:0];
          end
          if (g == 1) begin
            regs_nxt[g][15:0] = {8'h00, pc_r[23:16]};
          end
          if (g == 2) begin
            regs_nxt[g][15:0] = psr_r;
          end
        end else begin
          if (wr_en && wr_idx == 4'(g)) begin
            unique case (wr_size)
              CRF_SZ_BYTE: regs_nxt[g][7:0] = wr_data[7:0];
              CRF_SZ_WORD: regs_nxt[g][15:0] = wr_data[15:0];
              CRF_SZ_PAIR: begin
                if (wr_paired) begin
                  regs_nxt[g][15:0] = wr_data[15:0];
                end else begin
                  regs_nxt[g] = wr_data;
                end
              end
              default: regs_nxt[g] = regs_r[g];
            endcase
          end
          if (wr_en && wr_size == CRF_SZ_PAIR && wr_paired &&
              wr_up_idx == 4'(g)) begin
            regs_nxt[g][15:0] = wr_data[31:16];
          end
          if (g == CRF_NREG - 1 && stk_load && !user_mode_flag) begin
            regs_nxt[g] = stk_value;
          end
        end
        if (g < CRF_WIDE_FIRST) begin
          regs_nxt[g][31:16] = 16'h0000;
        end
      end
      assign regs_flat[g*32 +: 32] = regs_nxt[g];
    end
  endgenerate

  // Cold reset clears the bank; warm reset keeps it apart from R0-R2.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < CRF_NREG; i++) begin
        regs_r[i] <= 32'h00000000;
      end
    end else begin
      for (int i = 0; i < CRF_NREG; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
    end
  end

  crf_read_port u_port_a (
    .mclk(mclk),
    .reset_n(reset_n),
    .regs_flat(regs_flat),
    .short_reg(cfg_r[CRF_SHORT_REGISTER_SELECT]),
    .rd_idx(rd_a_idx),
    .rd_size(rd_a_size),
    .rd_data_r(rd_a_data)
  );

  crf_read_port u_port_b (
    .mclk(mclk),
    .reset_n(reset_n),
    .regs_flat(regs_flat),
    .short_reg(cfg_r[CRF_SHORT_REGISTER_SELECT]),
    .rd_idx(rd_b_idx),
    .rd_size(rd_b_size),
    .rd_data_r(rd_b_data)
  );

  // Instruction address counter; bit zero can never be set.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pc_r <= CRF_PC_START;
    end else if (warm_reset) begin
      pc_r <= CRF_PC_START;
    end else if (pc_load) begin
      pc_r <= {pc_value[23:1], 1'b0};
    end else if (bus_wr && bus_ofs == CRF_OFS_PC) begin
      pc_r <= {avs_writedata[23:1], 1'b0};
    end
  end

  // Interrupt stack: decremented on exception entry, restored on return.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      istk_r <= 32'h00000000;
    end else if (exc_push) begin
      istk_r <= (istk_r - {16'h0000, exc_bytes}) &
                CRF_ISTK_MASK;
    end else if (exc_pop) begin
      istk_r <= (istk_r + {16'h0000, exc_bytes}) &
                CRF_ISTK_MASK;
    end else if (bus_wr && bus_ofs == CRF_OFS_ISTK) begin
      istk_r <= crf_merge(istk_r, avs_writedata, avs_byteenable) &
                CRF_ISTK_MASK;
    end
  end

  // User stack pointer; stack updates in user mode land here.
  // A bus write in the same cycle as a user-mode core load is lost.
  always_comb begin
    ustk_nxt = ustk_r;
    if (stk_load && user_mode_flag) begin
      ustk_nxt = stk_value;
    end else if (bus_wr && bus_ofs == CRF_OFS_USTK) begin
      ustk_nxt = crf_merge(ustk_r, avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ustk_r <= 32'h00000000;
    end else begin
      ustk_r <= ustk_nxt;
    end
  end

  // The table base is stored as written; software keeps its unused bits
  // clear, so no masking is spent here.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      base_r <= 32'h00000000;
    end else if (bus_wr && bus_ofs == CRF_OFS_BASE) begin
      base_r <= crf_merge(base_r, avs_writedata, avs_byteenable);
    end
  end

  // Status word. Exception entry drops to supervisor mode.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      psr_r <= CRF_PSR_RESET;
    end else if (warm_reset) begin
      psr_r <= CRF_PSR_RESET;
    end else if (psr_load) begin
      psr_r <= psr_value & CRF_PSR_WMASK;
    end else if (exc_push) begin
      psr_r[CRF_USER_MODE_FLAG] <= 1'b0;
    end else if (bus_wr && bus_ofs == CRF_OFS_PSR) begin
      psr_r <= 16'(crf_merge({16'h0000, psr_r}, avs_writedata,
                             avs_byteenable)) & CRF_PSR_WMASK;
    end
  end

  // Configuration word; only the pairing and dispatch size bits exist.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= CRF_CFG_RESET;
    end else if (warm_reset) begin
      cfg_r <= CRF_CFG_RESET;
    end else if (bus_wr && bus_ofs == CRF_OFS_CFG) begin
      cfg_r <= 16'(crf_merge({16'h0000, cfg_r}, avs_writedata,
                             avs_byteenable)) & CRF_CFG_WMASK;
    end
  end

  // Active stack pointer follows the mode, and includes this cycle's update.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stack_ptr_r <= 32'h00000000;
    end else if (psr_r[CRF_USER_MODE_FLAG]) begin
      stack_ptr_r <= ustk_nxt;
    end else begin
      stack_ptr_r <= regs_nxt[CRF_IDX_SP];
    end
  end

  // The trap rises one edge after the offending access and stays high for as many cycles as the access is held.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      trap_r <= 1'b0;
    end else begin
      trap_r <= stk_access && user_mode_flag &&
                (ustk_r > CRF_USTK_LIMIT);
    end
  end

  always_comb begin
    unique case (bus_ofs)
      CRF_OFS_PC: readdata_nxt = {8'h00, pc_r};
      CRF_OFS_ISTK: readdata_nxt = istk_r;
      CRF_OFS_USTK: readdata_nxt = ustk_r;
      CRF_OFS_BASE: readdata_nxt = base_r;
      CRF_OFS_PSR: readdata_nxt = {16'h0000, psr_r};
      CRF_OFS_CFG: readdata_nxt = {16'h0000, cfg_r};
      CRF_OFS_STACK: readdata_nxt = stack_ptr_r;
      default: readdata_nxt = 32'h00000000;
    endcase
  end

  // Fixed one-wait-state slave: waitrequest drops for exactly one cycle
  // after a request is seen, then rises again for the next one.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      waitreq_r <= 1'b1;
    end else if (bus_req && waitreq_r) begin
      waitreq_r <= 1'b0;
    end else begin
      waitreq_r <= 1'b1;
    end
  end

  // Read data is captured as the request is first seen, so it already
  // stands at the edge where the master sees waitrequest low.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      readdata_r <= 32'h00000000;
    end else if (avs_read && waitreq_r) begin
      readdata_r <= readdata_nxt;
    end
  end

  assign instruction_address_counter = pc_r;
  assign processor_status_word = psr_r;
  assign short_register_select = cfg_r[CRF_SHORT_REGISTER_SELECT];
  assign stack_pointer = stack_ptr_r;
  assign interrupt_stack_pointer = istk_r;
  assign dispatch_table_base = base_r;
  assign illegal_address_trap = trap_r;
  assign avs_readdata = readdata_r;
  assign avs_waitrequest = waitreq_r;
endmodule
`default_nettype wire

// ---- testbench/crf_core_model.sv ----
// Model of the core exception logic driving the push and pop strobes.
`default_nettype none
module crf_core_model
  import crf_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic push_req,
  input wire logic pop_req,
  input wire logic [15:0] frame,
  output logic exc_push,
  output logic exc_pop,
  output logic [15:0] exc_bytes
);
  timeunit 1ns;
  timeprecision 100ps;
  int depth;
  // A pop is only issued when a push is outstanding, as the handler does.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      depth <= 0;
      exc_push <= 1'h0;
      exc_pop <= 1'h0;
      exc_bytes <= 16'h0;
    end else begin
      exc_push <= push_req;
      exc_pop <= pop_req && depth > 0;
      exc_bytes <= frame;
      depth <= depth + (push_req ? 1 : 0) - (pop_req && depth > 0 ? 1 : 0);
    end
  end
endmodule
`default_nettype wire

// ---- testbench/crf_regfile_sva.sv ----
// Concurrent checks on the register file ports.
`default_nettype none
module crf_regfile_sva
  import crf_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic warm_reset,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire crf_size_t wr_size,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] rd_a_idx,
  input wire crf_size_t rd_a_size,
  input wire logic [31:0] rd_a_data,
  input wire logic pc_load,
  input wire logic [23:0] pc_value,
  input wire logic [23:0] instruction_address_counter,
  input wire logic psr_load,
  input wire logic [15:0] processor_status_word,
  input wire logic short_register_select,
  input wire logic stk_access,
  input wire logic stk_load,
  input wire logic [31:0] stack_pointer,
  input wire logic exc_push,
  input wire logic exc_pop,
  input wire logic [15:0] exc_bytes,
  input wire logic [31:0] interrupt_stack_pointer,
  input wire logic illegal_address_trap,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_bus;
    s_req |=> s_ans;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");
  property p_pc_even;
    instruction_address_counter[0] == 1'h0;
  endproperty
  a_pc_even: assert property (p_pc_even) else $error("odd pc");
  property p_istk_mask;
    (interrupt_stack_pointer & ~CRF_ISTK_MASK) == 32'h0;
  endproperty
  a_istk_mask: assert property (p_istk_mask)
    else $error("stack bits");
  property p_trap;
    stk_access && !stk_load && processor_status_word[CRF_USER_MODE_FLAG] &&
      stack_pointer > CRF_USTK_LIMIT |=> illegal_address_trap;
  endproperty
  a_trap: assert property (p_trap) else $error("trap missing");
  property p_trap_cause;
    illegal_address_trap |-> $past(stk_access);
  endproperty
  a_trap_cause: assert property (p_trap_cause)
    else $error("bad trap");
  property p_pc_load;
    logic [23:0] v;
    (pc_load && !warm_reset, v = pc_value) |=>
      instruction_address_counter == {v[23:1], 1'h0};
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("pc load");
  property p_warm;
    warm_reset && !pc_load && !psr_load |=>
      instruction_address_counter == CRF_PC_START &&
      processor_status_word == CRF_PSR_RESET && !short_register_select;
  endproperty
  a_warm: assert property (p_warm) else $error("warm reset");
  property p_push;
    logic [31:0] v;
    (exc_push && !exc_pop, v = interrupt_stack_pointer - {16'h0, exc_bytes})
      |=> interrupt_stack_pointer == (v & CRF_ISTK_MASK);
  endproperty
  a_push: assert property (p_push) else $error("push stack");
  property p_push_u;
    exc_push && !psr_load |=> !processor_status_word[CRF_USER_MODE_FLAG];
  endproperty
  a_push_u: assert property (p_push_u) else $error("push mode");
  property p_fwd;
    logic [15:0] v;
    (wr_en && !stk_load && !warm_reset && wr_size == CRF_SZ_WORD &&
      rd_a_size == CRF_SZ_WORD && rd_a_idx == wr_idx, v = wr_data[15:0])
      |=> rd_a_data == {16'h0, v};
  endproperty
  a_fwd: assert property (p_fwd) else $error("no forward");
endmodule
bind crf_regfile crf_regfile_sva u_crf_regfile_sva (.mclk, .reset_n,
  .warm_reset, .wr_en, .wr_idx, .wr_size, .wr_data, .rd_a_idx, .rd_a_size,
  .rd_a_data, .pc_load, .pc_value, .instruction_address_counter, .psr_load,
  .processor_status_word, .short_register_select, .stk_access, .stk_load,
  .stack_pointer, .exc_push, .exc_pop, .exc_bytes, .interrupt_stack_pointer,
  .illegal_address_trap, .avs_read, .avs_write, .avs_waitrequest);
`default_nettype wire

// ---- testbench/crf_regfile_test.sv ----
// Self-checking testbench of the core register file.
`default_nettype none
module crf_regfile_test
  import crf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam crf_size_t B = CRF_SZ_BYTE;
  localparam crf_size_t W = CRF_SZ_WORD;
  localparam crf_size_t P = CRF_SZ_PAIR;
  logic mclk, reset_n, warm_reset, wr_en, pc_load, psr_load;
  logic stk_access, stk_load, push_req, pop_req, exc_push, exc_pop;
  logic avs_read, avs_write, avs_waitrequest, short_register_select;
  logic illegal_address_trap;
  logic [3:0] rd_a_idx, rd_b_idx, wr_idx;
  crf_size_t rd_a_size, rd_b_size, wr_size;
  logic [4:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [15:0] psr_value, processor_status_word, exc_bytes, frame;
  logic [23:0] pc_value, instruction_address_counter;
  logic [31:0] rd_a_data, rd_b_data, wr_data, stk_value, stack_pointer;
  logic [31:0] interrupt_stack_pointer, dispatch_table_base;
  logic [31:0] avs_writedata, avs_readdata, q;
  int num_errors, n_checks;
  crf_regfile u_crf_regfile (.mclk, .reset_n, .warm_reset, .rd_a_idx,
    .rd_a_size, .rd_a_data, .rd_b_idx, .rd_b_size, .rd_b_data, .wr_en,
    .wr_idx, .wr_size, .wr_data, .pc_load, .pc_value,
    .instruction_address_counter, .psr_load, .psr_value,
    .processor_status_word, .short_register_select, .stk_access, .stk_load,
    .stk_value, .stack_pointer, .exc_push, .exc_pop, .exc_bytes,
    .interrupt_stack_pointer, .dispatch_table_base, .illegal_address_trap,
    .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest);
  crf_core_model u_crf_core_model (.mclk, .reset_n, .push_req, .pop_req,
    .frame, .exc_push, .exc_pop, .exc_bytes);
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // The request is held until a rising edge samples waitrequest low; read
  // data is taken at that edge. One idle edge follows so that a next call
  // never drives the strobes twice in one time step.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge mclk); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic port(input logic we, input logic [3:0] wi,
    input crf_size_t ws,
    input logic [31:0] wd, input logic [3:0] ri, input crf_size_t rs,
    input logic [31:0] e);
    wr_en <= we;
    wr_idx <= wi;
    wr_size <= ws;
    wr_data <= wd;
    rd_a_idx <= ri;
    rd_b_idx <= ri;
    rd_a_size <= rs;
    rd_b_size <= rs;
    @(posedge mclk);
    wr_en <= 1'h0;
    @(negedge mclk);
    chk(rd_a_data, e);
    chk(rd_b_data, e);
    @(posedge mclk);
  endtask
  task automatic exc(input logic pu, input logic [31:0] e);
    push_req <= pu;
    pop_req <= !pu;
    @(posedge mclk);
    push_req <= 1'h0;
    pop_req <= 1'h0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(interrupt_stack_pointer, e);
    chk({31'h0, processor_status_word[CRF_USER_MODE_FLAG]}, 32'h0);
    @(posedge mclk);
  endtask
  initial begin
    #20000;
    num_errors++;
    close_out();
  end
  initial begin
    {reset_n, warm_reset, wr_en, pc_load, psr_load, stk_access} = 6'h0;
    {stk_load, push_req, pop_req, avs_read, avs_write} = 5'h0;
    {rd_a_idx, rd_b_idx, wr_idx, avs_address} = 17'h0;
    rd_a_size = B;
    rd_b_size = B;
    wr_size = B;
    avs_byteenable = 4'hf;
    {psr_value, frame, pc_value} = 56'h0;
    {wr_data, stk_value, avs_writedata} = 96'h0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'h1;
    @(posedge mclk);
    chk({8'h0, instruction_address_counter}, 32'h0);
    chk({16'h0, processor_status_word}, 32'h0200);
    bus(1'h1, 5'h00, 32'h00123457);
    rd(5'h00, 32'h00123456);
    bus(1'h1, 5'h04, 32'hffffffff);
    rd(5'h04, 32'h00fffffe);
    bus(1'h1, 5'h08, 32'h89abcdef);
    rd(5'h08, 32'h89abcdef);
    avs_byteenable <= 4'h1;
    bus(1'h1, 5'h08, 32'h11223344);
    avs_byteenable <= 4'hf;
    rd(5'h08, 32'h89abcd44);
    bus(1'h1, 5'h0c, 32'h00abcd00);
    chk(dispatch_table_base, 32'h00abcd00);
    rd(5'h0c, 32'h00abcd00);
    bus(1'h1, 5'h10, 32'h0000ffff);
    rd(5'h10, 32'h00000eef);
    bus(1'h1, 5'h1c, 32'h5a5a5a5a);
    rd(5'h1c, 32'h0);
    bus(1'h1, 5'h04, 32'h00002000);
    port(1'h1, 4'h3, W, 32'h1234, 4'h3, W, 32'h1234);
    port(1'h1, 4'h3, B, 32'hff, 4'h3, W, 32'h12ff);
    port(1'h0, 4'h0, B, 32'h0, 4'h3, B, 32'hff);
    port(1'h1, 4'h4, P, 32'haaaa5555, 4'h5, W, 32'haaaa);
    port(1'h0, 4'h0, W, 32'h0, 4'h4, P, 32'haaaa5555);
    port(1'h1, 4'h4, W, 32'h1111, 4'h4, P, 32'haaaa1111);
    port(1'h1, 4'hc, P, 32'h89abcdef, 4'hc, P, 32'h89abcdef);
    port(1'h1, 4'hd, P, 32'h76543210, 4'hc, W, 32'hcdef);
    port(1'h1, 4'hb, W, 32'h0bbb, 4'hb, P, 32'hcdef0bbb);
    bus(1'h1, 5'h14, 32'h00000200);
    chk({31'h0, short_register_select}, 32'h1);
    port(1'h0, 4'h0, W, 32'h0, 4'hc, P, 32'h3210cdef);
    port(1'h0, 4'h0, W, 32'h0, 4'hd, P, 32'h00003210);
    pc_load <= 1'h1;
    pc_value <= 24'h12a5c4;
    psr_load <= 1'h1;
    psr_value <= 16'h0e21;
    @(posedge mclk);
    {pc_load, psr_load, warm_reset} <= 3'h1;
    @(posedge mclk);
    warm_reset <= 1'h0;
    @(negedge mclk);
    chk({8'h0, instruction_address_counter}, 32'h0);
    chk({31'h0, short_register_select}, 32'h0);
    @(posedge mclk);
    port(1'h0, 4'h0, W, 32'h0, 4'h0, W, 32'ha5c4);
    port(1'h0, 4'h0, W, 32'h0, 4'h1, W, 32'h0012);
    port(1'h0, 4'h0, W, 32'h0, 4'h2, W, 32'h0e21);
    {stk_load, stk_value} <= 33'h100001000;
    @(posedge mclk);
    stk_load <= 1'h0;
    psr_load <= 1'h1;
    psr_value <= 16'h0008;
    @(posedge mclk);
    psr_load <= 1'h0;
    {stk_load, stk_value} <= 33'h101000000;
    @(posedge mclk);
    {stk_load, stk_access} <= 2'h1;
    @(posedge mclk);
    stk_access <= 1'h0;
    @(negedge mclk);
    chk({31'h0, illegal_address_trap}, 32'h1);
    chk(stack_pointer, 32'h01000000);
    @(posedge mclk);
    rd(5'h08, 32'h01000000);
    rd(5'h18, 32'h01000000);
    bus(1'h1, 5'h18, 32'h00000000);
    rd(5'h18, 32'h01000000);
    port(1'h0, 4'h0, W, 32'h0, 4'hf, P, 32'h1000);
    frame <= 16'h0010;
    exc(1'h1, 32'h00001ff0);
    exc(1'h0, 32'h00002000);
    close_out();
  end
endmodule
`default_nettype wire
